// *** core/afcw_regs.vh ***
// Purpose: Constants for the control-word register bank
// Assumes: 16-bit serial frames, six 8-bit control registers
// Notes: Offsets are 3-bit register addresses
`ifndef AFCW_REGS_VH
`define AFCW_REGS_VH
// Register addresses and register reset value
`define AFCW_ADDR_MODE 3'h0
`define AFCW_ADDR_CLOCK 3'h1
`define AFCW_ADDR_POWER 3'h2
`define AFCW_ADDR_GAIN 3'h3
`define AFCW_ADDR_DACT 3'h4
`define AFCW_ADDR_TEST 3'h5
`define AFCW_REG_RESET 8'h00
// Frame fields
`define AFCW_BIT_CTRL 15
`define AFCW_BIT_READ 14
`define AFCW_DEV_HI 13
`define AFCW_DEV_LO 11
`define AFCW_REG_HI 10
`define AFCW_REG_LO 8
`define AFCW_DATA_HI 7
`define AFCW_FRAME_BITS 16
`define AFCW_FRAME_LAST 4'hF
// Mode register fields
`define AFCW_MODE_RUN 0
`define AFCW_MODE_MIXED 1
`define AFCW_MODE_DLB 2
`define AFCW_MODE_SLB 3
`define AFCW_MODE_CNT_LO 4
`define AFCW_MODE_CNT_HI 6
`define AFCW_MODE_SWRST 7
// Clock register fields
`define AFCW_CLK_ECHO 7
// Power register fields
`define AFCW_PWR_GLOBAL 0
`define AFCW_PWR_ADC 3
`define AFCW_PWR_DAC 4
`define AFCW_PWR_REF 5
`define AFCW_PWR_REFOUT 6
`define AFCW_PWR_WMASK 8'h79
// Gain register fields
`define AFCW_GAIN_MODRST 3
`define AFCW_GAIN_MUTE 7
// Reset length in internal master clock cycles
`define AFCW_RESET_CYCLES 3'h4
`endif

// *** core/afcw_edge.v ***
// Purpose: Two-stage capture of a serial pin with edge pulses
// Assumes: Input synchronous to the clock, as stated
// Notes: Rise and fall are one-cycle pulses
`timescale 1ns/10ps
module afcw_edge
(
    input wire i_clk,
    input wire i_reset_n,
    input wire i_pin,
    output reg o_level,
    output wire o_rise,
    output wire o_fall
);
    reg prev_q; // Previous sampled level

    // Sample the pin and keep the last value
    always @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            o_level <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            o_level <= i_pin;
            prev_q <= o_level;
        end
    end

    assign o_rise = o_level & ~prev_q;
    assign o_fall = ~o_level & prev_q;
endmodule // afcw_edge

// *** core/afcw_bank.v ***
// Purpose: Control-word interpreter and register bank of the codec front end
// Assumes: Serial clock, frame sync and data inputs synchronous to I_MCLK
// Notes: Bits shift in MSB first on serial clock falling edges
//
// Functional notes
// - Global power bit powers ADC, DAC and reference, not reference output
// - Individual section bits act without global bit
// - Six 8-bit registers, reset zero, 6-7 reserved
// - Bit 15 is the control/data flag
// - Write data field when device address zero
// - Read copies register into outgoing data field
// - Nonzero device address decremented and forwarded
// - Bits 10-8 select the register
// - Bits 7-0 carry register data
// - Mode bit 0 data mode, bit 1 mixed
// - Mode bits 2,3 enable the two loopbacks
// - Mode bits 6-4 hold cascade count
// - Mode bit 7 starts a software reset
// - Clock register rate and divider fields
// - Clock bit 7 enables control echo
// - Power bits 0,3,4,5,6 drive sections
// - Gain bits 2-0 input, 6-4 output gain
// - Gain bit 3 holds modulator in reset
// - Gain bit 7 mutes analog output
// - Register updates on serial clock falling edge
// - Reset clears registers over four clock cycles
// - Plain data mode locks registers until reset
// - Mixed data frames go MSB-justified to DAC
`timescale 1ns/10ps
`include "afcw_regs.vh"
module afcw_bank
(
    input wire I_MCLK,
    input wire I_RESET_N,
    input wire I_SCLK,
    input wire I_INPUT_FRAME_SYNC,
    input wire I_SDI,
    output reg O_SDO,
    output reg O_OUTPUT_FRAME_SYNC,
    output reg [15:0] O_DAC_WORD,
    output reg O_DAC_LOAD,
    output reg O_RUN_MODE_SELECT,
    output reg O_MIXED_MODE_ENABLE,
    output reg O_DIGITAL_LOOP_ENABLE,
    output reg O_SERIAL_LOOP_ENABLE,
    output reg [2:0] O_CASCADE_COUNT,
    output reg [1:0] O_SAMPLE_RATE_CODE,
    output reg [1:0] O_SERIAL_CLOCK_DIV_CODE,
    output reg [2:0] O_MASTER_CLOCK_DIV_CODE,
    output reg O_CONTROL_ECHO_ENABLE,
    output reg O_ADC_POWER_ON,
    output reg O_DAC_POWER_ON,
    output reg O_REF_POWER_ON,
    output reg O_REF_OUTPUT_ENABLE,
    output reg [2:0] O_INPUT_GAIN_CODE,
    output reg [2:0] O_OUTPUT_GAIN_CODE,
    output reg O_MODULATOR_RESET,
    output reg O_OUTPUT_MUTE,
    output reg [7:0] O_DAC_TIMING,
    output reg [7:0] O_ANALOG_TEST,
    output reg O_IN_RESET
);
    // Frame states
    localparam ST_IDLE = 2'b00;
    localparam ST_RECV = 2'b01;
    localparam ST_SEND = 2'b10;

    wire sclk_lvl; // Sampled serial clock
    wire sclk_rise; // Serial clock rising pulse
    wire sclk_fall; // Serial clock falling pulse
    wire fs_lvl; // Sampled input frame sync
    reg [1:0] state_q; // Frame state
    reg [1:0] state_d;
    reg [3:0] bit_cnt_q; // Bit position within frame
    reg [3:0] bit_cnt_d;
    reg [15:0] shift_q; // Shared serial register
    reg [15:0] shift_d;
    reg [7:0] regs_q [0:5]; // Control registers
    reg [2:0] rst_cnt_q; // Reset sequence counter
    reg [2:0] rst_cnt_d;
    reg fs_seen_q; // Frame sync seen before next fall
    reg [2:0] frame_idx_q; // Data-mode frame counter for cascade
    reg [2:0] frame_idx_d;
    reg [15:0] frame_w; // Completed frame
    reg frame_done; // Last bit shifted in this cycle
    reg do_write; // Register write strobe
    reg do_send; // Start sending shifted word
    reg dac_load_d; // DAC load strobe
    reg [15:0] dac_d; // DAC word next value
    integer i;

    // Serial clock edge capture
    afcw_edge u_sclk
    (
        .i_clk(I_MCLK),
        .i_reset_n(I_RESET_N),
        .i_pin(I_SCLK),
        .o_level(sclk_lvl),
        .o_rise(sclk_rise),
        .o_fall(sclk_fall)
    );

    // Frame sync capture
    afcw_edge u_fsync
    (
        .i_clk(I_MCLK),
        .i_reset_n(I_RESET_N),
        .i_pin(I_INPUT_FRAME_SYNC),
        .o_level(fs_lvl),
        .o_rise(),
        .o_fall()
    );

    // Mode register views
    wire run_mode = regs_q[0][`AFCW_MODE_RUN];
    wire mixed = regs_q[0][`AFCW_MODE_MIXED];
    wire in_rst = (rst_cnt_q != 3'h0);
    // Control words accepted in program or mixed mode only
    wire ctrl_ok = !run_mode | mixed;

    // Frame assembly, decode and command choice
    always @*
    begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        frame_w = {shift_q[14:0], I_SDI};
        frame_done = 1'b0;
        do_write = 1'b0;
        do_send = 1'b0;
        dac_load_d = 1'b0;
        dac_d = O_DAC_WORD;
        frame_idx_d = frame_idx_q;
        case (state_q)
            ST_IDLE:
            begin
                // Frame starts on the fall that sees the sync
                if (sclk_fall && (fs_lvl || fs_seen_q))
                begin
                    shift_d = frame_w;
                    bit_cnt_d = 4'h1;
                    state_d = ST_RECV;
                end
            end
            ST_RECV:
            begin
                if (sclk_fall)
                begin
                    shift_d = frame_w;
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    if (bit_cnt_q == `AFCW_FRAME_LAST)
                    begin
                        frame_done = 1'b1;
                        bit_cnt_d = 4'h0;
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_SEND:
            begin
                // Shift the held word out on rising edges
                if (sclk_rise)
                begin
                    shift_d = {shift_q[14:0], 1'b0};
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    if (bit_cnt_q == `AFCW_FRAME_LAST)
                    begin
                        bit_cnt_d = 4'h0;
                        state_d = ST_IDLE;
                    end
                end
            end
            default:
            begin
                state_d = ST_IDLE;
                bit_cnt_d = 4'h0;
            end
        endcase
        // Interpret a complete frame
        if (frame_done && !in_rst)
        begin
            if (ctrl_ok && frame_w[`AFCW_BIT_CTRL])
            begin
                if (frame_w[`AFCW_DEV_HI:`AFCW_DEV_LO] != 3'h0)
                begin
                    shift_d = frame_w;
                    shift_d[`AFCW_DEV_HI:`AFCW_DEV_LO] = frame_w[`AFCW_DEV_HI:`AFCW_DEV_LO] - 3'h1;
                    do_send = 1'b1;
                end
                else if (frame_w[`AFCW_BIT_READ])
                begin
                    shift_d = frame_w;
                    if (frame_w[`AFCW_REG_HI:`AFCW_REG_LO] <= `AFCW_ADDR_TEST)
                        shift_d[`AFCW_DATA_HI:0] = regs_q[frame_w[`AFCW_REG_HI:`AFCW_REG_LO]];
                    else
                        shift_d[`AFCW_DATA_HI:0] = 8'h00; // Reserved address reads zero
                    do_send = 1'b1;
                end
                else
                begin
                    do_write = 1'b1;
                    if (O_CONTROL_ECHO_ENABLE)
                    begin
                        shift_d = frame_w;
                        do_send = 1'b1;
                    end
                end
            end
            else if (mixed && run_mode)
            begin
                dac_d = {frame_w[14:0], 1'b0};
                dac_load_d = 1'b1;
            end
            else if (run_mode)
            begin
                // Cascade slot counting, count of zero treated as one
                if (frame_idx_q + 3'h1 >= O_CASCADE_COUNT)
                begin
                    dac_d = frame_w;
                    dac_load_d = 1'b1;
                    frame_idx_d = 3'h0;
                end
                else
                    frame_idx_d = frame_idx_q + 3'h1;
            end
            // Zero flag in pure program mode: invalid word, dropped
        end
        if (do_send)
        begin
            state_d = ST_SEND;
            bit_cnt_d = 4'h0;
        end
    end

    // Sequencing, serial register and reset counter
    always @(posedge I_MCLK)
    begin
        if (!I_RESET_N)
        begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 16'h0000;
            fs_seen_q <= 1'b0;
            frame_idx_q <= 3'h0;
            rst_cnt_q <= 3'h0;
            O_SDO <= 1'b0;
            O_OUTPUT_FRAME_SYNC <= 1'b0;
            O_DAC_WORD <= 16'h0000;
            O_DAC_LOAD <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            frame_idx_q <= frame_idx_d;
            // Remember a sync pulse until the next falling edge; a fresh sync beats the clear
            if (fs_lvl)
                fs_seen_q <= 1'b1;
            else if (sclk_fall)
                fs_seen_q <= 1'b0;
            // Software reset runs four cycles
            if (do_write && frame_w[`AFCW_REG_HI:`AFCW_REG_LO] == `AFCW_ADDR_MODE
                && frame_w[`AFCW_MODE_SWRST])
                rst_cnt_q <= `AFCW_RESET_CYCLES;
            else if (in_rst)
                rst_cnt_q <= rst_cnt_q - 3'h1;
            O_SDO <= (state_d == ST_SEND) ? shift_d[15] : 1'b0;
            O_OUTPUT_FRAME_SYNC <= do_send;
            O_DAC_WORD <= dac_d;
            O_DAC_LOAD <= dac_load_d;
        end
    end

    // Control register bank
    always @(posedge I_MCLK)
    begin
        if (!I_RESET_N || in_rst)
        begin
            for (i = 0; i < 6; i = i + 1)
                regs_q[i] <= `AFCW_REG_RESET;
        end
        else if (do_write)
        begin
            case (frame_w[`AFCW_REG_HI:`AFCW_REG_LO])
                `AFCW_ADDR_MODE: regs_q[0] <= frame_w[`AFCW_DATA_HI:0];
                `AFCW_ADDR_CLOCK: regs_q[1] <= frame_w[`AFCW_DATA_HI:0];
                `AFCW_ADDR_POWER: regs_q[2] <= frame_w[`AFCW_DATA_HI:0] & `AFCW_PWR_WMASK;
                `AFCW_ADDR_GAIN: regs_q[3] <= frame_w[`AFCW_DATA_HI:0];
                `AFCW_ADDR_DACT: regs_q[4] <= frame_w[`AFCW_DATA_HI:0];
                `AFCW_ADDR_TEST: regs_q[5] <= frame_w[`AFCW_DATA_HI:0];
                default: regs_q[0] <= regs_q[0];
            endcase
        end
    end

    // Field outputs, registered
    always @(posedge I_MCLK)
    begin
        if (!I_RESET_N)
        begin
            O_RUN_MODE_SELECT <= 1'b0;
            O_MIXED_MODE_ENABLE <= 1'b0;
            O_DIGITAL_LOOP_ENABLE <= 1'b0;
            O_SERIAL_LOOP_ENABLE <= 1'b0;
            O_CASCADE_COUNT <= 3'h0;
            O_SAMPLE_RATE_CODE <= 2'h0;
            O_SERIAL_CLOCK_DIV_CODE <= 2'h0;
            O_MASTER_CLOCK_DIV_CODE <= 3'h0;
            O_CONTROL_ECHO_ENABLE <= 1'b0;
            O_ADC_POWER_ON <= 1'b0;
            O_DAC_POWER_ON <= 1'b0;
            O_REF_POWER_ON <= 1'b0;
            O_REF_OUTPUT_ENABLE <= 1'b0;
            O_INPUT_GAIN_CODE <= 3'h0;
            O_OUTPUT_GAIN_CODE <= 3'h0;
            O_MODULATOR_RESET <= 1'b0;
            O_OUTPUT_MUTE <= 1'b0;
            O_DAC_TIMING <= 8'h00;
            O_ANALOG_TEST <= 8'h00;
            O_IN_RESET <= 1'b0;
        end
        else
        begin
            O_RUN_MODE_SELECT <= regs_q[0][`AFCW_MODE_RUN];
            O_MIXED_MODE_ENABLE <= regs_q[0][`AFCW_MODE_MIXED];
            O_DIGITAL_LOOP_ENABLE <= regs_q[0][`AFCW_MODE_DLB];
            O_SERIAL_LOOP_ENABLE <= regs_q[0][`AFCW_MODE_SLB];
            O_CASCADE_COUNT <= regs_q[0][`AFCW_MODE_CNT_HI:`AFCW_MODE_CNT_LO];
            O_SAMPLE_RATE_CODE <= regs_q[1][1:0];
            O_SERIAL_CLOCK_DIV_CODE <= regs_q[1][3:2];
            O_MASTER_CLOCK_DIV_CODE <= regs_q[1][6:4];
            O_CONTROL_ECHO_ENABLE <= regs_q[1][`AFCW_CLK_ECHO];
            // Global bit overrides, individual bits stand alone
            O_ADC_POWER_ON <= regs_q[2][`AFCW_PWR_GLOBAL] | regs_q[2][`AFCW_PWR_ADC];
            O_DAC_POWER_ON <= regs_q[2][`AFCW_PWR_GLOBAL] | regs_q[2][`AFCW_PWR_DAC];
            O_REF_POWER_ON <= regs_q[2][`AFCW_PWR_GLOBAL] | regs_q[2][`AFCW_PWR_REF];
            O_REF_OUTPUT_ENABLE <= regs_q[2][`AFCW_PWR_REFOUT];
            O_INPUT_GAIN_CODE <= regs_q[3][2:0];
            O_OUTPUT_GAIN_CODE <= regs_q[3][6:4];
            O_MODULATOR_RESET <= regs_q[3][`AFCW_GAIN_MODRST];
            O_OUTPUT_MUTE <= regs_q[3][`AFCW_GAIN_MUTE];
            O_DAC_TIMING <= regs_q[4];
            O_ANALOG_TEST <= regs_q[5];
            O_IN_RESET <= in_rst;
        end
    end
endmodule // afcw_bank

// *** sim/afcw_bank_props.sv ***
// Purpose: Port-level checks on the control-word register bank
// Assumes: Serial clock half period of several master clock cycles
// Notes: Sees only the top module's ports; bound after the module
`timescale 1ns/10ps
module afcw_bank_props
(
    input wire I_MCLK,
    input wire I_RESET_N,
    input wire I_SCLK,
    input wire O_SDO,
    input wire O_OUTPUT_FRAME_SYNC,
    input wire [15:0] O_DAC_WORD,
    input wire O_DAC_LOAD,
    input wire O_RUN_MODE_SELECT,
    input wire O_MIXED_MODE_ENABLE,
    input wire O_DIGITAL_LOOP_ENABLE,
    input wire O_SERIAL_LOOP_ENABLE,
    input wire [2:0] O_CASCADE_COUNT,
    input wire [1:0] O_SAMPLE_RATE_CODE,
    input wire [1:0] O_SERIAL_CLOCK_DIV_CODE,
    input wire [2:0] O_MASTER_CLOCK_DIV_CODE,
    input wire O_CONTROL_ECHO_ENABLE,
    input wire O_ADC_POWER_ON,
    input wire O_DAC_POWER_ON,
    input wire O_REF_POWER_ON,
    input wire O_REF_OUTPUT_ENABLE,
    input wire [2:0] O_INPUT_GAIN_CODE,
    input wire [2:0] O_OUTPUT_GAIN_CODE,
    input wire O_MODULATOR_RESET,
    input wire O_OUTPUT_MUTE,
    input wire [7:0] O_DAC_TIMING,
    input wire [7:0] O_ANALOG_TEST,
    input wire O_IN_RESET
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESET_N);
    // All register field views in one bundle
    wire [42:0] fld = {O_RUN_MODE_SELECT, O_MIXED_MODE_ENABLE, O_DIGITAL_LOOP_ENABLE, O_SERIAL_LOOP_ENABLE,
        O_CASCADE_COUNT, O_SAMPLE_RATE_CODE, O_SERIAL_CLOCK_DIV_CODE, O_MASTER_CLOCK_DIV_CODE,
        O_CONTROL_ECHO_ENABLE, O_ADC_POWER_ON, O_DAC_POWER_ON, O_REF_POWER_ON, O_REF_OUTPUT_ENABLE,
        O_INPUT_GAIN_CODE, O_OUTPUT_GAIN_CODE, O_MODULATOR_RESET, O_OUTPUT_MUTE, O_DAC_TIMING, O_ANALOG_TEST};
    // Soft reset runs four cycles, with one cycle of slack
    sequence soft_run;
        O_IN_RESET [*4] ##[1:2] !O_IN_RESET;
    endsequence
    // Recent soft reset activity, when fields may clear off the serial clock
    wire soft_recent = O_IN_RESET;
    hw_reset_clear_a: assert property (disable iff (1'b0) !I_RESET_N ##1 !I_RESET_N |=> fld == 43'h0 && !O_OUTPUT_FRAME_SYNC)
        else $error("fields not cleared by reset");
    soft_reset_len_a: assert property ($rose(O_IN_RESET) |-> soft_run)
        else $error("soft reset length off");
    soft_clear_a: assert property ($fell(O_IN_RESET) |-> ##[0:2] (fld == 43'h0))
        else $error("fields not cleared by soft reset");
    regs_on_fall_a: assert property (!$stable(fld) && !soft_recent && !$past(O_IN_RESET) && !$past(O_IN_RESET, 2)
        && !$past(O_IN_RESET, 3) |-> !($past(I_SCLK, 2) && $past(I_SCLK, 3) && $past(I_SCLK, 4)
        && $past(I_SCLK, 5) && $past(I_SCLK, 6)))
        else $error("field changed without serial clock fall");
    data_lock_a: assert property (O_RUN_MODE_SELECT && !O_MIXED_MODE_ENABLE |=> $stable(fld))
        else $error("fields changed in data mode");
    sdo_shift_a: assert property (!$stable(O_SDO) |-> O_OUTPUT_FRAME_SYNC || $past(I_SCLK))
        else $error("serial out moved off a clock rise");
    output_frame_sync_word_a: assert property (O_OUTPUT_FRAME_SYNC |-> O_SDO)
        else $error("outgoing word lacks control flag");
    output_frame_sync_pulse_a: assert property (O_OUTPUT_FRAME_SYNC |=> !O_OUTPUT_FRAME_SYNC)
        else $error("frame sync longer than one cycle");
    dac_lsb_a: assert property (O_DAC_LOAD && O_MIXED_MODE_ENABLE |-> !O_DAC_WORD[0])
        else $error("mixed data word lsb not zero");
endmodule // afcw_bank_props
bind afcw_bank afcw_bank_props afcw_bank_props_inst
(
    .I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .I_SCLK(I_SCLK), .O_SDO(O_SDO), .O_OUTPUT_FRAME_SYNC(O_OUTPUT_FRAME_SYNC),
    .O_DAC_WORD(O_DAC_WORD), .O_DAC_LOAD(O_DAC_LOAD), .O_RUN_MODE_SELECT(O_RUN_MODE_SELECT),
    .O_MIXED_MODE_ENABLE(O_MIXED_MODE_ENABLE), .O_DIGITAL_LOOP_ENABLE(O_DIGITAL_LOOP_ENABLE),
    .O_SERIAL_LOOP_ENABLE(O_SERIAL_LOOP_ENABLE), .O_CASCADE_COUNT(O_CASCADE_COUNT),
    .O_SAMPLE_RATE_CODE(O_SAMPLE_RATE_CODE), .O_SERIAL_CLOCK_DIV_CODE(O_SERIAL_CLOCK_DIV_CODE),
    .O_MASTER_CLOCK_DIV_CODE(O_MASTER_CLOCK_DIV_CODE), .O_CONTROL_ECHO_ENABLE(O_CONTROL_ECHO_ENABLE),
    .O_ADC_POWER_ON(O_ADC_POWER_ON), .O_DAC_POWER_ON(O_DAC_POWER_ON), .O_REF_POWER_ON(O_REF_POWER_ON),
    .O_REF_OUTPUT_ENABLE(O_REF_OUTPUT_ENABLE), .O_INPUT_GAIN_CODE(O_INPUT_GAIN_CODE),
    .O_OUTPUT_GAIN_CODE(O_OUTPUT_GAIN_CODE), .O_MODULATOR_RESET(O_MODULATOR_RESET),
    .O_OUTPUT_MUTE(O_OUTPUT_MUTE), .O_DAC_TIMING(O_DAC_TIMING), .O_ANALOG_TEST(O_ANALOG_TEST),
    .O_IN_RESET(O_IN_RESET)
);

// *** sim/afcw_host_model.sv ***
// Purpose: Host serial port driving frames into the register bank
// Assumes: Serial clock idles high and stands still between frames
// Notes: The rise closing a frame and 15 more clocks bring a word back
`timescale 1ns/10ps
module afcw_host_model
(
    input wire i_clk,
    input wire i_sdo,
    output reg o_sclk,
    output reg o_input_frame_sync,
    output reg o_sdi
);
    // Serial clock half period in master clock cycles
    localparam integer HALF = 4;
    // Idle levels at time zero
    initial
    begin
        o_sclk = 1'b1;
        o_input_frame_sync = 1'b0;
        o_sdi = 1'b0;
    end
    // Wait a number of master clock edges
    task tick(input integer n);
        integer k;
        begin
            for (k = 0; k < n; k = k + 1)
                @(posedge i_clk);
        end
    endtask
    // Send a word MSB first, then clock back whatever the device sends
    task xfer(input [15:0] w, output [15:0] got);
        integer i;
        begin
            got = 16'h0000;
            for (i = 15; i >= 0; i = i - 1)
            begin
                o_sdi <= w[i];
                o_input_frame_sync <= (i == 15);
                tick(HALF);
                o_sclk <= 1'b0;
                tick(HALF);
                // First returned bit stands before the rise that closes the frame
                if (i == 0)
                    got[15] = i_sdo;
                o_sclk <= 1'b1;
            end
            o_input_frame_sync <= 1'b0;
            o_sdi <= ~w[0];
            // Each bit is taken just before the rise that shifts the next one out
            for (i = 14; i >= 0; i = i - 1)
            begin
                tick(HALF);
                o_sclk <= 1'b0;
                o_sdi <= ~o_sdi;
                tick(HALF);
                got[i] = i_sdo;
                o_sclk <= 1'b1;
            end
            tick(HALF);
        end
    endtask
endmodule // afcw_host_model

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the control-word register bank
// Assumes: Frames and readbacks go through the host model
// Notes: Plain data mode is left only by a hardware reset
`timescale 1ns/10ps
module testbench;
    reg I_MCLK;
    reg I_RESET_N;
    wire sclk, input_frame_sync, sdi, sdo, output_frame_sync, dac_load, run, mixed, digital_loop_enable, serial_loop_enable, echo, adc, dac, refp, refo, modr, mute, inrst;
    wire [15:0] dac_word;
    wire [2:0] cnt, mcd, igc, ogc;
    wire [1:0] rate, scd;
    wire [7:0] dact, atest;
    integer err_total, checked, cycles, a, loads;
    reg [15:0] got, dac_seen;
    // Table of write values, register 0 in the low byte; power keeps reserved bits zero
    localparam [47:0] TBL = 48'hE0_1F_B5_78_5B_30;
    afcw_bank afcw_bank_inst (.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .I_SCLK(sclk), .I_INPUT_FRAME_SYNC(input_frame_sync),
        .I_SDI(sdi), .O_SDO(sdo), .O_OUTPUT_FRAME_SYNC(output_frame_sync), .O_DAC_WORD(dac_word), .O_DAC_LOAD(dac_load),
        .O_RUN_MODE_SELECT(run), .O_MIXED_MODE_ENABLE(mixed), .O_DIGITAL_LOOP_ENABLE(digital_loop_enable),
        .O_SERIAL_LOOP_ENABLE(serial_loop_enable), .O_CASCADE_COUNT(cnt), .O_SAMPLE_RATE_CODE(rate),
        .O_SERIAL_CLOCK_DIV_CODE(scd), .O_MASTER_CLOCK_DIV_CODE(mcd), .O_CONTROL_ECHO_ENABLE(echo),
        .O_ADC_POWER_ON(adc), .O_DAC_POWER_ON(dac), .O_REF_POWER_ON(refp), .O_REF_OUTPUT_ENABLE(refo),
        .O_INPUT_GAIN_CODE(igc), .O_OUTPUT_GAIN_CODE(ogc), .O_MODULATOR_RESET(modr), .O_OUTPUT_MUTE(mute),
        .O_DAC_TIMING(dact), .O_ANALOG_TEST(atest), .O_IN_RESET(inrst));
    afcw_host_model afcw_host_model_inst (.i_clk(I_MCLK), .i_sdo(sdo), .o_sclk(sclk), .o_input_frame_sync(input_frame_sync), .o_sdi(sdi));
    // Register contents as seen on the field outputs
    function [15:0] view(input [2:0] r);
        case (r)
            3'h0: view = {9'h000, cnt, serial_loop_enable, digital_loop_enable, mixed, run};
            3'h1: view = {8'h00, echo, mcd, scd, rate};
            3'h2: view = {9'h000, refo, refp, dac, adc, 3'h0};
            3'h3: view = {8'h00, mute, ogc, modr, igc};
            3'h4: view = {8'h00, dact};
            3'h5: view = {8'h00, atest};
            default: view = 16'h0000;
        endcase
    endfunction
    // Compare and count
    task check(input [15:0] seen, input [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp)
            begin
                err_total = err_total + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Write and read frames to this device
    task wr(input [2:0] r, input [7:0] d);
        afcw_host_model_inst.xfer({5'b10000, r, d}, got);
    endtask
    task rd(input [2:0] r);
        afcw_host_model_inst.xfer({5'b11000, r, 8'h00}, got);
    endtask
    // Hold reset for 16 cycles
    task hw_reset;
        begin
            I_RESET_N <= 1'b0;
            repeat (16) @(posedge I_MCLK);
            I_RESET_N <= 1'b1;
            repeat (2) @(posedge I_MCLK);
        end
    endtask
    // Counts, verdict and end of run
    task finish_test;
        begin
            $display("errors %0d checks %0d", err_total, checked);
            if (err_total == 0 && checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // Master clock, 10 ns period
    initial
    begin
        I_MCLK = 1'b0;
        forever #5 I_MCLK = ~I_MCLK;
    end
    // Timeout and DAC load capture
    always @(posedge I_MCLK)
    begin
        cycles = cycles + 1;
        if (dac_load === 1'b1)
        begin
            dac_seen = dac_word;
            loads = loads + 1;
        end
        if (cycles == 60000)
        begin
            err_total = err_total + 1;
            finish_test;
        end
    end
    // Main sequence
    initial
    begin
        I_RESET_N = 1'b0;
        err_total = 0;
        checked = 0;
        cycles = 0;
        loads = 0;
        dac_seen = 16'h0000;
        @(posedge I_MCLK);
        hw_reset;
        for (a = 0; a < 6; a = a + 1)
            check(view(a[2:0]), 16'h0000);
        for (a = 0; a < 6; a = a + 1)
            wr(a[2:0], TBL[a * 8 +: 8]);
        for (a = 0; a < 6; a = a + 1)
        begin
            rd(a[2:0]);
            check(got, {5'b11000, a[2:0], TBL[a * 8 +: 8]});
            check(view(a[2:0]), {8'h00, TBL[a * 8 +: 8]});
        end
        wr(3'h6, 8'hFF);
        rd(3'h6);
        check(got, 16'hC600);
        for (a = 0; a < 6; a = a + 1)
            check(view(a[2:0]), {8'h00, TBL[a * 8 +: 8]});
        afcw_host_model_inst.xfer(16'h9B5A, got);
        check(got, 16'h935A);
        check(view(3'h3), 16'h00B5);
        afcw_host_model_inst.xfer(16'h0311, got);
        check(view(3'h3), 16'h00B5);
        wr(3'h2, 8'h01);
        check({13'h0, adc, dac, refp}, 16'h0007);
        wr(3'h2, 8'h20);
        check({13'h0, adc, dac, refp}, 16'h0001);
        wr(3'h1, 8'hDB);
        check(view(3'h1), 16'h00DB);
        wr(3'h0, 8'h0C);
        check(view(3'h0), 16'h000C);
        wr(3'h0, 8'h80);
        for (a = 0; a < 6; a = a + 1)
            check(view(a[2:0]), 16'h0000);
        wr(3'h0, 8'h03);
        check(view(3'h0), 16'h0003);
        a = loads;
        afcw_host_model_inst.xfer(16'h1234, got);
        check(dac_seen, 16'h2468);
        check(loads[15:0] - a[15:0], 16'h0001);
        wr(3'h3, 8'h42);
        check(view(3'h3), 16'h0042);
        wr(3'h0, 8'h01);
        afcw_host_model_inst.xfer(16'h8311, got);
        check(view(3'h3), 16'h0042);
        check(dac_seen, 16'h8311);
        hw_reset;
        check(view(3'h0), 16'h0000);
        // Data mode with two devices in cascade: every second frame is ours
        wr(3'h0, 8'h21);
        a = loads;
        afcw_host_model_inst.xfer(16'h0ABC, got);
        check(loads[15:0] - a[15:0], 16'h0000);
        afcw_host_model_inst.xfer(16'h0DEF, got);
        check(dac_seen, 16'h0DEF);
        finish_test;
    end
endmodule // testbench
